/* fsp_pkg.sv */
// Purpose: Shared constants and types of the four-mode serial port.
// Assumes: One 40 MHz core clock; registers reached over a plain port.
// Notes:   Offsets and divider figures are named here once.

package fsp_pkg;

  // ----------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_CTRL = 2'h0;  // Serial port control.
  localparam logic [1:0] ADDR_DATA = 2'h1;  // Serial data buffer.
  localparam logic [1:0] ADDR_PWR  = 2'h2;  // Power control.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int         PWR_DOUBLE_POS = 7;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  // Shift-register mode clock is core clock over 12, held per half period.
  localparam logic [3:0] M0_HALF_LAST = 4'h5;
  // Fixed-rate oversampling tick: 64/16 = 4 cycles, or 32/16 = 2 cycles.
  localparam logic [1:0] FIX_DIV_NORM = 2'h3;
  localparam logic [1:0] FIX_DIV_FAST = 2'h1;
  localparam logic [3:0] OVS_LAST = 4'hf;  // 16 ticks per bit.
  localparam logic [3:0] OVS_MID  = 4'h7;  // Sample point in a bit.

  // ----------------------------------------------------------------
  // Frame shape.
  // ----------------------------------------------------------------
  localparam logic [2:0] M0_LAST_BIT  = 3'h7;
  localparam logic [3:0] TX_LAST_8    = 4'h9;  // Index of stop bit, 10 bits.
  localparam logic [3:0] TX_LAST_9    = 4'ha;  // Index of stop bit, 11 bits.
  localparam logic [3:0] RX_LAST_SHIFT = 4'h8;
  localparam logic [3:0] RX_DONE_8    = 4'h8;
  localparam logic [3:0] RX_DONE_9    = 4'h9;

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiprocessor_filter;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic receive_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } fsp_ctrl_s;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fsp_req_s;

  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100} fsp_tx_e;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} fsp_rx_e;
  typedef enum logic [1:0] {M0_IDLE = 2'b01, M0_SHIFT = 2'b10} fsp_m0_e;

endpackage

/* fsp_remote.sv */
// Purpose: Remote serial peer and external shift register on the serial pins.
// Assumes: Bit times are given in core clock cycles by the caller.
// Notes:   Samples on the falling clock edge so it never races the device.

`timescale 1ns/1ps

module fsp_remote (
  // Clock.
  input  wire logic clk,
  // Device pins.
  input  wire logic txd,
  input  wire logic rxd_out,
  input  wire logic rxd_oe_n,
  output logic      rxd_in
);
  // --------------------------------------------------------------
  // Pin drive.
  // --------------------------------------------------------------
  logic drv_q = 1'b1;

  // The device wins the receive pin while its enable is low.
  assign rxd_in = rxd_oe_n ? drv_q : rxd_out;

  // Waits, bounded, until txd leaves level lv and comes back to it.
  task automatic txd_to(input logic lv);
    int n;
    n = 0;
    while (txd === lv && n < 200) begin
      @(negedge clk);
      n++;
    end
    while (txd !== lv && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Sends a low start bit, then nb bits LSB first, each bc cycles long.
  task automatic send(input int nb, input logic [9:0] frm, input int bc);
    drv_q <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      drv_q <= frm[i];
      repeat (bc) @(posedge clk);
    end
    drv_q <= 1'b1;
  endtask

  // Captures nb bits after the start bit at mid-bit; all unknown if none starts.
  task automatic recv(input int nb, input int bc, output logic [9:0] frm);
    int n;
    frm = 'x;
    n = 0;
    while (txd !== 1'b0 && n < 40 * bc) begin
      @(negedge clk);
      n++;
    end
    if (n < 40 * bc) begin
      frm = '0;
      repeat (bc / 2) @(negedge clk);
      for (int i = 0; i < nb; i++) begin
        repeat (bc) @(negedge clk);
        frm[i] = txd;
      end
    end
  endtask

  // Shift register side: bit 8 of got records any release seen.
  task automatic m0_recv(output logic [9:0] got);
    got = '0;
    for (int i = 0; i < 8; i++) begin
      txd_to(1'b1);
      got[i] = rxd_out;
      got[8] = got[8] | rxd_oe_n;
    end
  endtask

  // Shift register side: presents each bit after a falling shift clock.
  task automatic m0_send(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      txd_to(1'b0);
      @(posedge clk);
      drv_q <= d[i];
    end
    txd_to(1'b1);
    @(posedge clk);
    drv_q <= 1'b1;
  endtask

endmodule  // fsp_remote

/* fsp_serial_port.sv */
// Purpose: Four-mode full-duplex serial port with control and data registers.
// Assumes: Timer overflow pulses arrive on the core clock; rxd is a pin.
// Notes:   Receive pin is two-way in shift-register mode; oe low drives it.
//
// Behaviour
// R01: 8-bit async, filter on: bad stop suppresses flag.
// R02: 9-bit, filter on: ninth bit 0 suppresses flag.
// R03: Receive only while receive enable set.
// R04: 9-bit modes send transmit ninth bit.
// R05: Receive ninth bit holds ninth or stop bit.
// R06: Transmit flag set at eighth bit or stop.
// R07: Receive flag set at eighth bit or mid-stop.
// R08: Mode 0 is shift register, clock on txd.
// R09: Mode 0 write sends eight bits LSB first.
// R10: Mode 0 receive starts when enabled, flag clear.
// R11: 8-bit frame: start, eight data, stop.
// R12: Variable modes clock from timer overflow pulses.
// R13: 8-bit write loads stop bit as ninth.
// R14: Async receive starts on falling edge.
// R15: Final shift stores byte only if allowed.
// R16: Mode 2 rate is clock over 64 or 32.
// R17: 9-bit frame holds eleven bits.
// R18: 9-bit transmit waits for next baud tick.
// R19: 9-bit receive stores byte and ninth bit.
// R20: Mode 3 is mode 2 with timer rate.
// R21: Data address writes transmit, reads receive.
// R22: Receiver is double buffered.
// R23: Start bit must still be low mid-bit.
// R24: Software clears flags before next frame.

`timescale 1ns/1ps

module fsp_serial_port (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              resetn,
  // Register port.
  input  wire fsp_pkg::fsp_req_s req,
  output logic [7:0]             rd_data,
  // Baud sources for the variable-rate modes.
  input  wire logic              tx_timer_ovf,
  input  wire logic              rx_timer_ovf,
  // Serial pins.
  input  wire logic              rxd_in,
  output logic                   rxd_out,
  output logic                   rxd_oe_n,
  output logic                   txd
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  fsp_pkg::fsp_ctrl_s ctrl_q;
  fsp_pkg::fsp_tx_e   tx_st_q;
  fsp_pkg::fsp_rx_e   rx_st_q;
  fsp_pkg::fsp_m0_e   m0_st_q;
  logic        baud_double_q;
  logic [7:0]  rx_buf_q, rd_data_q;
  logic        rxd_m_q, rxd_s_q, rxd_p_q;
  logic [1:0]  fix_pre_q;
  logic        tx_half_q, rx_half_q;
  logic [3:0]  tx_ovs_q, rx_ph_q, tx_idx_q, rx_idx_q;
  logic [10:0] tx_sh_q;
  logic        tx_line_q, txd_q;
  logic [8:0]  rx_sh_q;
  logic [3:0]  m0_div_q;
  logic        m0_hi_q, m0_rx_q, m0_clk_q, rxd_out_q, rxd_oe_n_q;
  logic [2:0]  m0_cnt_q;
  logic [7:0]  m0_sh_q;
  logic        mode0, mode1, nine, fix_tick, tx_tick, rx_tick, tx_bit_tick;
  logic        wr_ctrl, wr_data, m0_half, m0_tx_go, m0_rx_go, m0_end;
  logic        a_ti_set, rx_mid, rx_done, rx_b9, ri_set, ti_set, rb8_d;
  logic [7:0]  rx_data, ri_data;
  logic [3:0]  tx_last;

  // ----------------------------------------------------------------
  // Mode decode and register strobes.
  // ----------------------------------------------------------------
  // Mode select bits pick shift register, 8-bit or 9-bit framing.
  assign mode0 = !ctrl_q.mode_select_high && !ctrl_q.mode_select_low;  // R08
  assign mode1 = !ctrl_q.mode_select_high && ctrl_q.mode_select_low;
  assign nine  = ctrl_q.mode_select_high;
  assign wr_ctrl = req.wr && (req.addr == fsp_pkg::ADDR_CTRL);
  assign wr_data = req.wr && (req.addr == fsp_pkg::ADDR_DATA);  // R21

  // ----------------------------------------------------------------
  // Baud ticks.
  // ----------------------------------------------------------------
  // Fixed prescaler gives 16 ticks per bit at clock over 64 or 32.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fix_pre_q <= 2'h0;
    end else if (fix_pre_q == 2'h0) begin
      fix_pre_q <= baud_double_q ? fsp_pkg::FIX_DIV_FAST : fsp_pkg::FIX_DIV_NORM;  // R16
    end else begin
      fix_pre_q <= fix_pre_q - 2'h1;
    end
  end
  assign fix_tick = (fix_pre_q == 2'h0);

  // Without rate doubling only every second overflow counts.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_half_q <= 1'b0;
      rx_half_q <= 1'b0;
    end else begin
      tx_half_q <= tx_half_q ^ tx_timer_ovf;
      rx_half_q <= rx_half_q ^ rx_timer_ovf;
    end
  end

  // Variable modes take each direction's tick from its own timer.
  assign tx_tick = mode1 || (nine && ctrl_q.mode_select_low) ?
                   tx_timer_ovf && (baud_double_q || tx_half_q) : fix_tick;  // R12 R20
  assign rx_tick = mode1 || (nine && ctrl_q.mode_select_low) ?
                   rx_timer_ovf && (baud_double_q || rx_half_q) : fix_tick;  // R12 R20

  // Free-running transmit bit counter marks valid bit boundaries.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_ovs_q <= 4'h0;
    end else if (tx_tick) begin
      tx_ovs_q <= tx_ovs_q + 4'h1;
    end
  end
  assign tx_bit_tick = tx_tick && (tx_ovs_q == fsp_pkg::OVS_LAST);

  // ----------------------------------------------------------------
  // Pin synchroniser.
  // ----------------------------------------------------------------
  // Two flops, then a third stage for the falling-edge compare.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      rxd_p_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd_in;
      rxd_s_q <= rxd_m_q;
      rxd_p_q <= rxd_s_q;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous transmitter.
  // ----------------------------------------------------------------
  // Stop index is 9 for 10-bit frames, 10 for 11-bit frames.
  assign tx_last  = nine ? fsp_pkg::TX_LAST_9 : fsp_pkg::TX_LAST_8;  // R11 R17
  assign a_ti_set = (tx_st_q == fsp_pkg::TX_SEND) && tx_bit_tick
                    && (tx_idx_q + 4'h1 == tx_last);  // R06

  // Frame is start, data LSB first, ninth slot, stop; sent from bit 0.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_q   <= fsp_pkg::TX_IDLE;
      tx_sh_q   <= '1;
      tx_idx_q  <= 4'h0;
      tx_line_q <= 1'b1;
    end else if (wr_data && !mode0) begin
      tx_sh_q <= {1'b1, nine ? ctrl_q.transmit_ninth_bit : 1'b1, req.wdata, 1'b0};  // R04 R13
      tx_st_q <= fsp_pkg::TX_WAIT;
    end else begin
      case (tx_st_q)
        fsp_pkg::TX_WAIT: begin
          if (tx_bit_tick) begin  // R18
            tx_line_q <= tx_sh_q[0];
            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
            tx_idx_q  <= 4'h0;
            tx_st_q   <= fsp_pkg::TX_SEND;
          end
        end
        fsp_pkg::TX_SEND: begin
          if (tx_bit_tick) begin
            if (tx_idx_q == tx_last) begin
              tx_st_q <= fsp_pkg::TX_IDLE;
            end else begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
              tx_idx_q  <= tx_idx_q + 4'h1;
            end
          end
        end
        default: begin
          tx_line_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous receiver.
  // ----------------------------------------------------------------
  // Completion is mid stop bit; 8-bit mode captures the stop live.
  assign rx_mid  = rx_tick && (rx_ph_q == fsp_pkg::OVS_MID);
  assign rx_done = (rx_st_q == fsp_pkg::RX_DATA) && rx_mid
                   && (rx_idx_q == (nine ? fsp_pkg::RX_DONE_9 : fsp_pkg::RX_DONE_8));  // R07
  assign rx_data = nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
  assign rx_b9   = nine ? rx_sh_q[8] : rxd_s_q;  // R05 R19

  // Shift register is separate from the buffer, so reads overlap frames.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_q  <= fsp_pkg::RX_IDLE;
      rx_ph_q  <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q  <= 9'h000;
    end else if (!ctrl_q.receive_enable || mode0) begin
      rx_st_q <= fsp_pkg::RX_IDLE;  // R03
    end else begin
      if (rx_tick) begin
        rx_ph_q <= rx_ph_q + 4'h1;
      end
      case (rx_st_q)
        fsp_pkg::RX_IDLE: begin
          if (rxd_p_q && !rxd_s_q) begin  // R14
            rx_ph_q <= 4'h0;
            rx_st_q <= fsp_pkg::RX_START;
          end
        end
        fsp_pkg::RX_START: begin
          if (rx_mid) begin
            rx_idx_q <= 4'h0;
            rx_st_q  <= rxd_s_q ? fsp_pkg::RX_IDLE : fsp_pkg::RX_DATA;  // R23
          end
        end
        fsp_pkg::RX_DATA: begin
          if (rx_mid) begin
            if (rx_idx_q <= fsp_pkg::RX_LAST_SHIFT) begin
              rx_sh_q <= {rxd_s_q, rx_sh_q[8:1]};  // R22
            end
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_done) begin
              rx_st_q <= fsp_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          rx_st_q <= fsp_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift-register mode engine.
  // ----------------------------------------------------------------
  assign m0_half  = (m0_div_q == fsp_pkg::M0_HALF_LAST);
  assign m0_tx_go = mode0 && wr_data;  // R09
  assign m0_rx_go = mode0 && (m0_st_q == fsp_pkg::M0_IDLE) && !wr_data
                    && ctrl_q.receive_enable && !ctrl_q.receive_done_flag;  // R10
  assign m0_end   = (m0_st_q == fsp_pkg::M0_SHIFT) && m0_half && m0_hi_q
                    && (m0_cnt_q == fsp_pkg::M0_LAST_BIT);

  // Clock low half drives data, rising edge samples, eighth high ends it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m0_st_q    <= fsp_pkg::M0_IDLE;
      m0_div_q   <= 4'h0;
      m0_hi_q    <= 1'b0;
      m0_rx_q    <= 1'b0;
      m0_cnt_q   <= 3'h0;
      m0_sh_q    <= 8'h00;
      m0_clk_q   <= 1'b1;
      rxd_out_q  <= 1'b1;
      rxd_oe_n_q <= 1'b1;
    end else if (m0_tx_go || m0_rx_go) begin
      m0_st_q    <= fsp_pkg::M0_SHIFT;
      m0_div_q   <= 4'h0;
      m0_hi_q    <= 1'b0;
      m0_rx_q    <= m0_rx_go;
      m0_cnt_q   <= 3'h0;
      m0_sh_q    <= req.wdata;
      m0_clk_q   <= 1'b0;  // R08
      rxd_out_q  <= req.wdata[0];
      rxd_oe_n_q <= m0_rx_go;
    end else if (m0_st_q == fsp_pkg::M0_SHIFT) begin
      m0_div_q <= m0_half ? 4'h0 : m0_div_q + 4'h1;
      if (!mode0 || m0_end) begin
        m0_st_q    <= fsp_pkg::M0_IDLE;
        m0_clk_q   <= 1'b1;
        rxd_oe_n_q <= 1'b1;
      end else if (m0_half && !m0_hi_q) begin
        m0_sh_q  <= {rxd_s_q, m0_sh_q[7:1]};
        m0_hi_q  <= 1'b1;
        m0_clk_q <= 1'b1;
      end else if (m0_half) begin
        m0_hi_q   <= 1'b0;
        m0_clk_q  <= 1'b0;
        m0_cnt_q  <= m0_cnt_q + 3'h1;
        rxd_out_q <= m0_sh_q[0];  // R09
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag set terms.
  // ----------------------------------------------------------------
  // A frame lands only with the flag clear and, in the async modes, the filter satisfied.
  assign ti_set  = a_ti_set || (m0_end && !m0_rx_q);  // R06
  assign ri_set  = (m0_end && m0_rx_q && !ctrl_q.receive_done_flag)
                   || (rx_done && !ctrl_q.receive_done_flag
                       && (!ctrl_q.multiprocessor_filter || rx_b9));  // R01 R02 R15
  assign ri_data = m0_end ? m0_sh_q : rx_data;
  assign rb8_d   = m0_end ? ctrl_q.receive_ninth_bit : rx_b9;

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  // Hardware sets win over a software write in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q        <= fsp_pkg::CTRL_RESET;
      baud_double_q <= 1'b0;
      rx_buf_q      <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= req.wdata;
      end
      if (req.wr && (req.addr == fsp_pkg::ADDR_PWR)) begin
        baud_double_q <= req.wdata[fsp_pkg::PWR_DOUBLE_POS];
      end
      if (ti_set) begin
        ctrl_q.transmit_done_flag <= 1'b1;  // R06
      end
      if (ri_set) begin
        ctrl_q.receive_done_flag <= 1'b1;  // R07
        ctrl_q.receive_ninth_bit <= rb8_d;  // R05
        rx_buf_q                 <= ri_data;  // R15 R19
      end
    end
  end

  // Read data stands the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= 8'h00;
    end else if (!req.rd) begin
      rd_data_q <= 8'h00;
    end else if (req.addr == fsp_pkg::ADDR_CTRL) begin
      rd_data_q <= ctrl_q;
    end else if (req.addr == fsp_pkg::ADDR_DATA) begin
      rd_data_q <= rx_buf_q;  // R21
    end else if (req.addr == fsp_pkg::ADDR_PWR) begin
      rd_data_q <= {baud_double_q, 7'h00};
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  // Transmit pin carries the shift clock in mode 0, else the frame.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= mode0 ? m0_clk_q : tx_line_q;  // R08
    end
  end

  assign rd_data  = rd_data_q;
  assign rxd_out  = rxd_out_q;
  assign rxd_oe_n = rxd_oe_n_q;
  assign txd      = txd_q;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_tx_begin;
    tx_st_q == fsp_pkg::TX_WAIT && tx_bit_tick && !wr_data;
  endsequence
  sequence s_start_low;
    !tx_line_q ##1 !tx_line_q;
  endsequence
  property p_tx_start_bit;
    s_tx_begin |=> s_start_low;
  endproperty
  a_tx_start_bit: assert property (p_tx_start_bit) else $error("Start bit not low.");  // R11

  property p_ti_on_stop;
    $rose(ctrl_q.transmit_done_flag) && !mode0 |-> tx_line_q;
  endproperty
  a_ti_on_stop: assert property (p_ti_on_stop) else $error("Transmit flag off stop bit.");  // R06

  property p_rx_needs_enable;
    rx_st_q == fsp_pkg::RX_IDLE ##1 rx_st_q != fsp_pkg::RX_IDLE |-> $past(ctrl_q.receive_enable);
  endproperty
  a_rx_needs_enable: assert property (p_rx_needs_enable) else $error("Receive began while disabled.");  // R03

  property p_filter;
    $rose(ctrl_q.receive_done_flag) && !mode0 && ctrl_q.multiprocessor_filter
      |-> ctrl_q.receive_ninth_bit;
  endproperty
  a_filter: assert property (p_filter) else $error("Filtered frame raised flag.");  // R01 R02

  property p_m0_tx_start;
    m0_tx_go |=> m0_st_q == fsp_pkg::M0_SHIFT && !rxd_oe_n && rxd_out == $past(req.wdata[0]);
  endproperty
  a_m0_tx_start: assert property (p_m0_tx_start) else $error("Mode 0 transmit did not start.");  // R09

  property p_m0_rx_start;
    m0_rx_go |=> m0_st_q == fsp_pkg::M0_SHIFT && rxd_oe_n && !m0_clk_q;
  endproperty
  a_m0_rx_start: assert property (p_m0_rx_start) else $error("Mode 0 receive did not start.");  // R10

  property p_read_data;
    req.rd && req.addr == fsp_pkg::ADDR_DATA |=> rd_data == $past(rx_buf_q);
  endproperty
  a_read_data: assert property (p_read_data) else $error("Data read not receive buffer.");  // R21

  property p_start_glitch;
    rx_st_q == fsp_pkg::RX_START && rx_mid && rxd_s_q && ctrl_q.receive_enable && !mode0
      |=> rx_st_q == fsp_pkg::RX_IDLE;
  endproperty
  a_start_glitch: assert property (p_start_glitch) else $error("False start not dropped.");  // R23

  property p_no_overrun_set;
    rx_done && ctrl_q.receive_done_flag |=> rx_buf_q == $past(rx_buf_q);
  endproperty
  a_no_overrun_set: assert property (p_no_overrun_set) else $error("Frame stored over set flag.");  // R15

endmodule // fsp_serial_port

/* tb.sv */
// Purpose: Self-checking bench of the four-mode serial port.
// Assumes: Timer overflows pulse every second clock, so one bit is 64 clocks, or 32 with rate doubling.
// Notes:   Async frames run as table rows; odd cases follow by hand.

`timescale 1ns/1ps

module tb;
  // --------------------------------------------------------------
  // Signals and rows.
  // --------------------------------------------------------------
  typedef struct {
    logic [7:0] ctrl, pwr, tx;
    logic [9:0] rxf;
    int         nb, bc;
    logic [9:0] txf, ectl, ebuf;
  } fsp_row_s;

  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  fsp_pkg::fsp_req_s req = '0;
  logic [7:0]        rd_data;
  logic              tx_ovf = 1'b0;
  logic              rx_ovf = 1'b0;
  logic              rxd_in, rxd_out, rxd_oe_n, txd;
  logic [9:0]        v, got;
  int                num_errors = 0;
  int                n_compared = 0;
  fsp_row_s          rows [7] = '{
    '{8'hb0, 8'h00, 8'h5a, 10'h233, 10, 64, 10'h25a, 10'h0b2, 10'h000},
    '{8'h70, 8'h00, 8'hc3, 10'h0f0, 9, 64, 10'h1c3, 10'h072, 10'h000},
    '{8'h50, 8'h00, 8'h01, 10'h0a5, 9, 64, 10'h101, 10'h053, 10'h0a5},
    '{8'h70, 8'h00, 8'h80, 10'h13c, 9, 64, 10'h180, 10'h077, 10'h03c},
    '{8'h98, 8'h80, 8'h81, 10'h27e, 10, 32, 10'h381, 10'h09b, 10'h07e},
    '{8'hf0, 8'h00, 8'h00, 10'h3e7, 10, 64, 10'h200, 10'h0f7, 10'h0e7},
    '{8'hd8, 8'h80, 8'hff, 10'h301, 10, 32, 10'h3ff, 10'h0df, 10'h001}};

  // Clock of 25 ns.
  always #12.5 clk = ~clk;

  // Transmit and receive timers overflow every second clock, out of phase.
  always @(posedge clk) begin
    tx_ovf <= ~tx_ovf;
    rx_ovf <= tx_ovf;
  end

  fsp_serial_port u_dut (
    .clk          (clk),
    .resetn       (resetn),
    .req          (req),
    .rd_data      (rd_data),
    .tx_timer_ovf (tx_ovf),
    .rx_timer_ovf (rx_ovf),
    .rxd_in       (rxd_in),
    .rxd_out      (rxd_out),
    .rxd_oe_n     (rxd_oe_n),
    .txd          (txd)
  );

  fsp_remote u_rem (
    .clk      (clk),
    .txd      (txd),
    .rxd_out  (rxd_out),
    .rxd_oe_n (rxd_oe_n),
    .rxd_in   (rxd_in)
  );

  // --------------------------------------------------------------
  // Tasks.
  // --------------------------------------------------------------
  // Compares and counts.
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] seen);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude;
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [1:0] a, output logic [9:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    @(negedge clk);
    d = {2'h0, rd_data};
  endtask

  // Polls the control register until the receive flag shows, bounded.
  task automatic poll_rx;
    int n;
    n = 0;
    v = '0;
    while (v[0] !== 1'b1 && n < 60) begin
      rd(fsp_pkg::ADDR_CTRL, v);
      n++;
    end
    if (n == 60) begin
      num_errors++;
      conclude();
    end
  endtask

  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    conclude();
  end

  // --------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    check("txd in reset", 10'h001, {9'h0, txd});
    check("oe in reset", 10'h001, {9'h0, rxd_oe_n});
    check("rd_data in reset", 10'h000, {2'h0, rd_data});
    @(posedge clk);
    resetn <= 1'b1;
    rd(fsp_pkg::ADDR_CTRL, v);
    check("ctrl reset", 10'h000, v);
    wr(2'h3, 8'hff);
    rd(2'h3, v);
    check("unmapped", 10'h000, v);
    // Full-duplex frames; each control write also clears both flags.
    foreach (rows[i]) begin
      wr(fsp_pkg::ADDR_PWR, rows[i].pwr);
      wr(fsp_pkg::ADDR_CTRL, rows[i].ctrl);
      fork
        u_rem.recv(rows[i].nb, rows[i].bc, got);
        u_rem.send(rows[i].nb, rows[i].rxf, rows[i].bc);
        wr(fsp_pkg::ADDR_DATA, rows[i].tx);
      join
      check("tx frame", rows[i].txf, got);
      rd(fsp_pkg::ADDR_CTRL, v);
      check("ctrl", rows[i].ectl, v);
      rd(fsp_pkg::ADDR_DATA, v);
      check("buffer", rows[i].ebuf, v);
    end
    // The last row left rate doubling on; power control reads it back.
    rd(fsp_pkg::ADDR_PWR, v);
    check("power", 10'h080, v);
    // Second frame while the flag is still set is dropped.
    u_rem.send(10, 10'h3aa, 32);
    rd(fsp_pkg::ADDR_CTRL, v);
    check("overrun ctrl", 10'h0df, v);
    rd(fsp_pkg::ADDR_DATA, v);
    check("overrun buffer", 10'h001, v);
    // A short low pulse is no start bit.
    wr(fsp_pkg::ADDR_CTRL, 8'h90);
    u_rem.send(0, 10'h000, 6);
    repeat (400) @(posedge clk);
    rd(fsp_pkg::ADDR_CTRL, v);
    check("glitch ctrl", 10'h090, v);
    // Receiver switched off ignores a whole frame.
    wr(fsp_pkg::ADDR_CTRL, 8'h80);
    u_rem.send(10, 10'h3c3, 32);
    rd(fsp_pkg::ADDR_CTRL, v);
    check("disabled ctrl", 10'h080, v);
    rd(fsp_pkg::ADDR_DATA, v);
    check("disabled buffer", 10'h001, v);
    // Shift register transmit, then receive.
    wr(fsp_pkg::ADDR_CTRL, 8'h00);
    fork
      u_rem.m0_recv(got);
      wr(fsp_pkg::ADDR_DATA, 8'h96);
    join
    check("shift out", 10'h096, got);
    // The eighth high phase still runs six clocks after the last rise.
    repeat (8) @(posedge clk);
    rd(fsp_pkg::ADDR_CTRL, v);
    check("shift tx ctrl", 10'h002, v);
    fork
      u_rem.m0_send(8'h5a);
      wr(fsp_pkg::ADDR_CTRL, 8'h10);
    join
    poll_rx();
    check("shift rx ctrl", 10'h011, v);
    rd(fsp_pkg::ADDR_DATA, v);
    check("shift in", 10'h05a, v);
    conclude();
  end

endmodule  // tb
